// file: rtl/rcs_pkg.sv
// Purpose: Shared constants for the reset and clock source controller
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes:   Offsets are byte addresses; each register is one aligned word
package rcs_pkg;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int SYS_CLK_HZ    = 10_000_000;
    localparam int CLK_PER_US    = SYS_CLK_HZ / 1_000_000;
    localparam int BROWN_CLR_US  = 500;
    localparam int BROWN_CLR_CYC = BROWN_CLR_US * CLK_PER_US;
    localparam int RST_HOLD_CYC  = 16;
    localparam int CNT_W         = 16;
    localparam int HOLD_W        = 5;
    localparam int WD_W          = 32;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] SUPPLY_FAULT_RESET_CTRL_OFS = 8'h00;
    localparam logic [7:0] REGULATOR_CTRL_REG_OFS      = 8'h04;
    localparam logic [7:0] RUN_CLOCK_CONFIG_REG_OFS    = 8'h08;
    localparam logic [7:0] RESET_CAUSE_REG_OFS         = 8'h0c;
    localparam logic [7:0] PERIPH_SW_RESET0_OFS        = 8'h10;
    localparam logic [7:0] PERIPH_SW_RESET1_OFS        = 8'h14;
    localparam logic [7:0] PERIPH_SW_RESET2_OFS        = 8'h18;
    localparam logic [7:0] BROWN_STATUS_OFS            = 8'h1c;
    localparam logic [7:0] WDOG_RELOAD_VALUE_OFS       = 8'h20;
    localparam logic [7:0] WDOG_CTRL_OFS               = 8'h24;
    localparam logic [7:0] WDOG_INT_CLEAR_OFS          = 8'h28;
    localparam logic [7:0] WDOG_COUNT_OFS              = 8'h2c;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int SF_WAIT_BIT   = 0;
    localparam int SF_RSTSEL_BIT = 1;
    localparam int SF_DLY_LSB    = 16;
    localparam int RG_TRIM_LSB   = 0;
    localparam int RG_FLTEN_BIT  = 8;
    localparam int RC_SRC_LSB    = 4;
    localparam int RC_BYPASS_BIT = 11;
    localparam int CA_EXT_BIT    = 0;
    localparam int CA_POR_BIT    = 1;
    localparam int CA_BROWN_BIT  = 2;
    localparam int CA_SW_BIT     = 3;
    localparam int CA_WDOG_BIT   = 4;
    localparam int CA_LDO_BIT    = 5;
    localparam int BS_IRQ_BIT    = 0;
    localparam int BS_COND_BIT   = 1;
    localparam int WC_EN_BIT     = 0;
    localparam int WC_RSTEN_BIT  = 1;
    localparam int WC_IRQ_BIT    = 2;

    // --------------------------------------------------------------
    // Regulator trim and reset values
    // --------------------------------------------------------------
    localparam int TRIM_MIN_MV  = 2250;
    localparam int TRIM_MAX_MV  = 2750;
    localparam int TRIM_STEP_MV = 50;
    localparam logic [3:0] TRIM_MAX = 4'((TRIM_MAX_MV - TRIM_MIN_MV) / TRIM_STEP_MV);
    localparam logic [3:0] TRIM_RST = 4'h5;
    localparam logic [5:0] CAUSE_RST = 6'h02;

    // Oscillator source encodings
    typedef enum logic [1:0] {
        OSC_MAIN     = 2'h0,
        OSC_INT      = 2'h1,
        OSC_INT_DIV4 = 2'h2
    } rcs_osc_t;
endpackage

// file: rtl/rcs_reset_clock_ctrl.sv
// Purpose: Reset gathering, peripheral resets, watchdog, regulator trim and
//          system clock source selection, with APB register access
// Assumes: Detector and pin inputs are asynchronous; core request is on sys_clk
// Notes:   Controls also return to defaults on every internal reset, cause bits stay sticky
// Function
// [RULE_01] Brown-out reset is off after power-up; software may enable it.
// [RULE_02] A brown-out raises either an interrupt or a system reset.
// [RULE_03] Brown-out resets only when the reset-select bit is set.
// [RULE_04] With wait set and reset clear, resample after delay; absent means nothing.
// [RULE_05] Qualified brown-out with reset selected asserts internal reset.
// [RULE_06] Internal brown-out condition clears 500 us after it is set.
// [RULE_07] After reset release the core fetches stack pointer, counter, instruction.
// [RULE_08] Three peripheral reset registers; set then clear resets that peripheral.
// [RULE_09] Peripheral reset bit layout equals the clock gating bit layout.
// [RULE_10] A peripheral reset asserts all resets of every clock domain of it.
// [RULE_11] Core system reset request resets whole system including core, then releases.
// [RULE_12] Watchdog interrupts on first time-out, may reset on the second.
// [RULE_13] After first time-out the 32-bit counter reloads and keeps counting.
// [RULE_14] Watchdog resets only if enabled and zero again with interrupt uncleared.
// [RULE_15] Enabled regulator fault sets its flag and resets; off after power-up.
// [RULE_16] Regulator trim field sets output from 2.25 V to 2.75 V in steps.
// [RULE_17] System clock comes from internal, main, internal/4 oscillator or PLL.
// [RULE_18] Source code 0x0 main, 0x1 internal, 0x2 internal divided by four.
// [RULE_19] Bypass 0 routes source through PLL; bypass 1 drives clock directly.
// [RULE_20] Software keeps PLL reference between 3.579545 and 8.192 MHz.
// [RULE_21] Sticky reset cause bits; an external pin reset clears the others.
// [RULE_22] System resets spare test access logic; peripheral resets spare the core.
// [RULE_23] Requests are synchronised and internal reset is held a fixed time.
`timescale 1ns/1ns
`default_nettype none

module rcs_reset_clock_ctrl
    import rcs_pkg::*;
#(
    parameter int BROWN_CLR_CYCLES = BROWN_CLR_CYC,
    parameter int RST_HOLD_CYCLES  = RST_HOLD_CYC
) (
    input  wire logic        sys_clk,         // System clock
    input  wire logic        resetn,          // Power-on reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error on unmapped address
    input  wire logic        brownDetect,     // Supply below threshold, async
    input  wire logic        regFaultDetect,  // Regulator out of regulation, async
    input  wire logic        extRstPinN,      // External reset pin, async
    input  wire logic        coreSysResetReq, // Core system reset request
    output logic             coreRstN,        // Core and system reset, active low
    output logic             bootFetch,       // Pulse: core may start its fetch
    output logic      [31:0] periphRst0,      // Peripheral resets, group 0
    output logic      [31:0] periphRst1,      // Peripheral resets, group 1
    output logic      [31:0] periphRst2,      // Peripheral resets, group 2
    output logic             brownIrq,        // Brown-out interrupt level
    output logic             wdogIrq,         // Watchdog interrupt level
    output logic      [3:0]  regTrim,         // Regulator voltage trim
    output logic      [1:0]  clkSrcSel,       // Oscillator source select
    output logic             pllSelect        // 1: system clock from PLL
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]        brSyn;
        logic [2:0]        ldoSyn;
        logic [2:0]        extSyn;
        logic              brLvl;
        logic              ldoLvl;
        logic              extLvl;
        logic              brCond;
        logic [CNT_W-1:0]  brClrCnt;
        logic              brWait;
        logic [CNT_W-1:0]  brWaitCnt;
        logic              brIrq;
        logic              resetSel;
        logic              waitEn;
        logic [CNT_W-1:0]  resampleDly;
        logic [3:0]        trim;
        logic              ldoRstEn;
        logic [1:0]        oscillator_source_select;
        logic              bypass;
        logic [5:0]        cause;
        logic [31:0]       prst0;
        logic [31:0]       prst1;
        logic [31:0]       prst2;
        logic [WD_W-1:0]   wdLoad;
        logic [WD_W-1:0]   wdCnt;
        logic              wdEn;
        logic              wdRstEn;
        logic              wdIrq;
        logic [HOLD_W-1:0] rstCnt;
        logic              coreRstN;
        logic              fetchGo;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } rcs_state_t;

    rcs_state_t s_r;
    rcs_state_t s_nxt;

    // Three-stage synchroniser step; level moves once stages two and three agree
    function automatic logic [3:0] syncStep(logic [2:0] stg, logic lvl, logic din);
        logic nl;
        nl = lvl;
        if (stg[1] == stg[2]) begin
            nl = stg[2];
        end
        return {nl, stg[1:0], din};
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [3:0]  sy;
        logic        setup;
        logic        wr;
        logic        hit;
        logic [31:0] rd;
        logic        brSet;
        logic        brReq;
        logic        ldoReq;
        logic        extReq;
        logic        wdReq;
        logic        anyReq;
        sy     = '0;
        rd     = '0;
        hit    = 1'b1;
        brReq  = 1'b0;
        wdReq  = 1'b0;
        anyReq = 1'b0;
        setup  = psel && !penable;
        wr     = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
        brSet  = s_r.brLvl && !s_r.brCond;
        ldoReq = s_r.ldoLvl && s_r.ldoRstEn;                         // RULE_15
        extReq = !s_r.extLvl;
        s_nxt  = s_r;
        // Synchronise asynchronous inputs
        sy = syncStep(s_r.brSyn, s_r.brLvl, brownDetect);            // RULE_23
        s_nxt.brLvl = sy[3];
        s_nxt.brSyn = sy[2:0];
        sy = syncStep(s_r.ldoSyn, s_r.ldoLvl, regFaultDetect);       // RULE_23
        s_nxt.ldoLvl = sy[3];
        s_nxt.ldoSyn = sy[2:0];
        sy = syncStep(s_r.extSyn, s_r.extLvl, extRstPinN);           // RULE_23
        s_nxt.extLvl = sy[3];
        s_nxt.extSyn = sy[2:0];
        // APB: setup captures read data, access edge commits writes
        unique case (paddr)
            SUPPLY_FAULT_RESET_CTRL_OFS: begin
                rd[SF_WAIT_BIT]   = s_r.waitEn;
                rd[SF_RSTSEL_BIT] = s_r.resetSel;
                rd[SF_DLY_LSB +: CNT_W] = s_r.resampleDly;
            end
            REGULATOR_CTRL_REG_OFS: begin
                rd[RG_TRIM_LSB +: 4] = s_r.trim;
                rd[RG_FLTEN_BIT]     = s_r.ldoRstEn;
            end
            RUN_CLOCK_CONFIG_REG_OFS: begin
                rd[RC_SRC_LSB +: 2] = s_r.oscillator_source_select;
                rd[RC_BYPASS_BIT]   = s_r.bypass;
            end
            RESET_CAUSE_REG_OFS:   rd[5:0] = s_r.cause;
            PERIPH_SW_RESET0_OFS:  rd = s_r.prst0;
            PERIPH_SW_RESET1_OFS:  rd = s_r.prst1;
            PERIPH_SW_RESET2_OFS:  rd = s_r.prst2;
            BROWN_STATUS_OFS: begin
                rd[BS_IRQ_BIT]  = s_r.brIrq;
                rd[BS_COND_BIT] = s_r.brCond;
            end
            WDOG_RELOAD_VALUE_OFS: rd = s_r.wdLoad;
            WDOG_CTRL_OFS: begin
                rd[WC_EN_BIT]    = s_r.wdEn;
                rd[WC_RSTEN_BIT] = s_r.wdRstEn;
                rd[WC_IRQ_BIT]   = s_r.wdIrq;
            end
            WDOG_INT_CLEAR_OFS:    rd = '0;
            WDOG_COUNT_OFS:        rd = s_r.wdCnt;
            default:               hit = 1'b0;
        endcase
        s_nxt.pready = setup;
        if (setup) begin
            s_nxt.prdata  = rd;
            s_nxt.pslverr = !hit;
        end
        // Register writes
        if (wr) begin
            unique case (paddr)
                SUPPLY_FAULT_RESET_CTRL_OFS: begin
                    s_nxt.waitEn      = pwdata[SF_WAIT_BIT];
                    s_nxt.resetSel    = pwdata[SF_RSTSEL_BIT];       // RULE_01
                    s_nxt.resampleDly = pwdata[SF_DLY_LSB +: CNT_W];
                end
                REGULATOR_CTRL_REG_OFS: begin
                    s_nxt.trim = (pwdata[RG_TRIM_LSB +: 4] > TRIM_MAX) ? TRIM_MAX : pwdata[RG_TRIM_LSB +: 4]; // RULE_16
                    s_nxt.ldoRstEn = pwdata[RG_FLTEN_BIT];
                end
                RUN_CLOCK_CONFIG_REG_OFS: begin
                    // Reserved source code 0x3 leaves the source unchanged
                    if (pwdata[RC_SRC_LSB +: 2] != 2'h3) begin
                        s_nxt.oscillator_source_select = pwdata[RC_SRC_LSB +: 2];      // RULE_18
                    end
                    s_nxt.bypass = pwdata[RC_BYPASS_BIT];            // RULE_19
                end
                RESET_CAUSE_REG_OFS:   s_nxt.cause = s_r.cause & ~pwdata[5:0];
                PERIPH_SW_RESET0_OFS:  s_nxt.prst0 = pwdata;         // RULE_08
                PERIPH_SW_RESET1_OFS:  s_nxt.prst1 = pwdata;         // RULE_08
                PERIPH_SW_RESET2_OFS:  s_nxt.prst2 = pwdata;         // RULE_08
                BROWN_STATUS_OFS:      s_nxt.brIrq = s_r.brIrq && !pwdata[BS_IRQ_BIT];
                WDOG_RELOAD_VALUE_OFS: begin
                    s_nxt.wdLoad = pwdata;
                    s_nxt.wdCnt  = pwdata;
                end
                WDOG_CTRL_OFS: begin
                    s_nxt.wdEn    = pwdata[WC_EN_BIT];
                    s_nxt.wdRstEn = pwdata[WC_RSTEN_BIT];
                end
                WDOG_INT_CLEAR_OFS:    s_nxt.wdIrq = 1'b0;
                default: ;
            endcase
        end
        // Brown-out condition: set once, then blocked until it clears
        if (brSet) begin
            s_nxt.brCond   = 1'b1;
            s_nxt.brClrCnt = '0;
            if (s_r.resetSel) begin
                brReq = 1'b1;                                        // RULE_03 RULE_05
            end else if (s_r.waitEn) begin
                s_nxt.brWait    = 1'b1;                              // RULE_04
                s_nxt.brWaitCnt = '0;
            end else begin
                s_nxt.brIrq = 1'b1;                                  // RULE_02
            end
        end else if (s_r.brCond) begin
            if (s_r.brClrCnt == CNT_W'(BROWN_CLR_CYCLES - 1)) begin
                s_nxt.brCond = 1'b0;                                 // RULE_06
            end else begin
                s_nxt.brClrCnt = s_r.brClrCnt + 1'b1;
            end
        end
        // Noise filter: resample the level after the programmed delay
        if (s_r.brWait) begin
            if (s_r.brWaitCnt >= s_r.resampleDly) begin
                s_nxt.brWait = 1'b0;
                if (s_r.brLvl) begin
                    s_nxt.brIrq = 1'b1;                              // RULE_04 RULE_02
                end
            end else begin
                s_nxt.brWaitCnt = s_r.brWaitCnt + 1'b1;
            end
        end
        // Watchdog down counter with two-stage time-out
        if (s_r.wdEn) begin
            if (s_r.wdCnt == '0) begin
                s_nxt.wdCnt = s_r.wdLoad;                            // RULE_13
                if (!s_r.wdIrq) begin
                    s_nxt.wdIrq = 1'b1;                              // RULE_12
                end else if (s_r.wdRstEn) begin
                    wdReq = 1'b1;                                    // RULE_14
                end
            end else begin
                s_nxt.wdCnt = s_r.wdCnt - 1'b1;
            end
        end
        // Other reset requests
        anyReq = brReq || ldoReq || extReq || wdReq || coreSysResetReq; // RULE_11
        // Sticky cause bits; a pin reset leaves only its own bit
        if (extReq) begin
            s_nxt.cause = 6'h01 << CA_EXT_BIT;                       // RULE_21
        end else begin
            if (brReq) begin
                s_nxt.cause[CA_BROWN_BIT] = 1'b1;                    // RULE_21
            end
            if (coreSysResetReq) begin
                s_nxt.cause[CA_SW_BIT] = 1'b1;                       // RULE_21
            end
            if (wdReq) begin
                s_nxt.cause[CA_WDOG_BIT] = 1'b1;                     // RULE_21
            end
            if (ldoReq) begin
                s_nxt.cause[CA_LDO_BIT] = 1'b1;                      // RULE_15
            end
        end
        // Internal reset hold counter
        if (anyReq) begin
            s_nxt.rstCnt = HOLD_W'(RST_HOLD_CYCLES);                 // RULE_23
        end else if (s_r.rstCnt != '0) begin
            s_nxt.rstCnt = s_r.rstCnt - 1'b1;
        end
        s_nxt.coreRstN = (s_nxt.rstCnt == '0);                       // RULE_11 RULE_22
        s_nxt.fetchGo  = !s_r.coreRstN && s_nxt.coreRstN;            // RULE_07
        // System reset returns controls to defaults, keeps cause bits
        if (!s_nxt.coreRstN) begin
            s_nxt.resetSel    = 1'b0;                                // RULE_01
            s_nxt.waitEn      = 1'b0;
            s_nxt.resampleDly = '0;
            s_nxt.ldoRstEn    = 1'b0;                                // RULE_15
            s_nxt.trim        = TRIM_RST;
            s_nxt.oscillator_source_select      = OSC_MAIN;
            s_nxt.bypass      = 1'b1;
            s_nxt.wdEn        = 1'b0;
            s_nxt.wdRstEn     = 1'b0;
            s_nxt.wdIrq       = 1'b0;
            s_nxt.wdLoad      = '1;
            s_nxt.wdCnt       = '1;
            s_nxt.brIrq       = 1'b0;
            s_nxt.brWait      = 1'b0;
            // All peripherals held in reset with the system
            s_nxt.prst0 = '1;                                        // RULE_22
            s_nxt.prst1 = '1;
            s_nxt.prst2 = '1;
        end else if (!s_r.coreRstN) begin
            s_nxt.prst0 = '0;
            s_nxt.prst1 = '0;
            s_nxt.prst2 = '0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r          <= '0;
            s_r.extSyn   <= 3'h7;
            s_r.extLvl   <= 1'b1;
            s_r.bypass   <= 1'b1;
            s_r.trim     <= TRIM_RST;
            s_r.cause    <= CAUSE_RST;
            s_r.wdLoad   <= '1;
            s_r.wdCnt    <= '1;
            s_r.rstCnt   <= HOLD_W'(RST_HOLD_CYCLES);
            s_r.prst0    <= '1;
            s_r.prst1    <= '1;
            s_r.prst2    <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Each bit feeds every domain reset of its unit; layout as clock gating
    assign periphRst0 = s_r.prst0;                                   // RULE_09 RULE_10
    assign periphRst1 = s_r.prst1;                                   // RULE_09 RULE_10
    assign periphRst2 = s_r.prst2;                                   // RULE_09 RULE_10
    assign prdata     = s_r.prdata;
    assign pready     = s_r.pready;
    assign pslverr    = s_r.pslverr;
    assign coreRstN   = s_r.coreRstN;
    assign bootFetch  = s_r.fetchGo;
    assign brownIrq   = s_r.brIrq;
    assign wdogIrq    = s_r.wdIrq;
    assign regTrim    = s_r.trim;
    // Source and PLL path for the clock mux outside
    assign clkSrcSel  = s_r.oscillator_source_select;                                  // RULE_17
    assign pllSelect  = !s_r.bypass;                                 // RULE_19

endmodule

`default_nettype wire

// file: sim/rcs_reset_clock_ctrl_assertions.sv
// Purpose: Port checks of the reset and clock source controller
// Assumes: One clock domain, resetn active low
// Notes:   Attached by bind below
`timescale 1ns/1ns
`default_nettype none
module rcs_ctrl_checker #(
    parameter int RST_HOLD_CYCLES = 16
) (
    input wire logic        sys_clk,         // Clock
    input wire logic        resetn,          // Reset
    input wire logic        psel,            // Select
    input wire logic        penable,         // Enable
    input wire logic        pready,          // Ready
    input wire logic        coreSysResetReq, // Request
    input wire logic        coreRstN,        // Core reset
    input wire logic        bootFetch,       // Fetch
    input wire logic [31:0] periphRst0,      // Group 0
    input wire logic [3:0]  regTrim,         // Trim
    input wire logic [1:0]  clkSrcSel,       // Source
    input wire logic        pllSelect        // PLL
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    int lowCnt;
    // Cycles spent in the current internal reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            lowCnt <= 0;
        else
            lowCnt <= coreRstN ? 0 : lowCnt + 1;
    end
    sequence s_setup; psel && !penable; endsequence
    sequence s_release; !coreRstN ##1 coreRstN; endsequence
    sequence s_heldLow; !coreRstN ##1 !coreRstN; endsequence
    property p_bootRise; s_release |-> bootFetch; endproperty
    a_bootRise: assert property (p_bootRise) else $error("no fetch pulse");
    property p_bootOnly; bootFetch |-> $rose(coreRstN); endproperty
    a_bootOnly: assert property (p_bootOnly) else $error("stray fetch pulse");
    property p_periph; !coreRstN |-> &periphRst0; endproperty
    a_periph: assert property (p_periph) else $error("peripherals free in reset");
    property p_sysReq; coreSysResetReq |=> !coreRstN; endproperty
    a_sysReq: assert property (p_sysReq) else $error("request ignored");
    property p_hold; s_release |-> lowCnt >= RST_HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("reset too short");
    property p_apb; s_setup |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("bad ready");
    property p_trim; regTrim <= 4'ha; endproperty
    a_trim: assert property (p_trim) else $error("trim out of range");
    property p_src; clkSrcSel != 2'h3; endproperty
    a_src: assert property (p_src) else $error("illegal source");
    property p_dflt; s_heldLow |-> regTrim == 4'h5 && clkSrcSel == 2'h0 && !pllSelect; endproperty
    a_dflt: assert property (p_dflt) else $error("defaults lost");
endmodule
bind rcs_reset_clock_ctrl rcs_ctrl_checker #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_chk (
    .sys_clk, .resetn, .psel, .penable, .pready, .coreSysResetReq,
    .coreRstN, .bootFetch, .periphRst0, .regTrim, .clkSrcSel, .pllSelect
);
`default_nettype wire

// file: sim/reset_and_clock_source_ctrl_test.sv
// Purpose: Self-checking bench of the reset and clock source controller
// Assumes: Short brown-out and hold counts
// Notes:   APB master drives after rising edges
`timescale 1ns/1ns
`default_nettype none
module reset_and_clock_source_ctrl_test import rcs_pkg::*; ;
    logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic        brownDetect = 0, regFaultDetect = 0, extRstPinN = 1, coreSysResetReq = 0;
    logic        pready, pslverr, coreRstN, bootFetch, brownIrq, wdogIrq, pllSelect;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, periphRst0, periphRst1, periphRst2, exp;
    logic [95:0] pr;
    logic [3:0]  regTrim;
    logic [1:0]  clkSrcSel;
    int          errors = 0, num_checks = 0, n;
    assign pr = {periphRst2, periphRst1, periphRst0};
    rcs_reset_clock_ctrl #(.BROWN_CLR_CYCLES(20), .RST_HOLD_CYCLES(4)) dut (
        .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .brownDetect, .regFaultDetect, .extRstPinN, .coreSysResetReq, .coreRstN, .bootFetch,
        .periphRst0, .periphRst1, .periphRst2, .brownIrq, .wdogIrq, .regTrim, .clkSrcSel, .pllSelect
    );
    // Clock of 100 ns
    initial forever #50 sys_clk = ~sys_clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge sys_clk);
        q = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) errors++;
        repeat (2) @(negedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(q, e);
    endtask
    task waitCore(input logic v);
        for (n = 0; coreRstN !== v && n < 200; n++) @(posedge sys_clk);
        if (n == 200) errors++;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task t_defaults;
        rd(SUPPLY_FAULT_RESET_CTRL_OFS, 32'h0);
        rd(REGULATOR_CTRL_REG_OFS, 32'h5);
        rd(RUN_CLOCK_CONFIG_REG_OFS, 32'h800);
        rd(8'h30, 32'h0);
        chk(se, 1);
        $display("defaults test done");
    endtask
    task t_clock;
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 2; b++) begin
                wr(RUN_CLOCK_CONFIG_REG_OFS, (32'(b) << 11) | (32'(s) << 4));
                chk(clkSrcSel, s == 3 ? 2'h2 : 2'(s));
                chk(pllSelect, !b);
            end
        wr(REGULATOR_CTRL_REG_OFS, 32'hf);
        chk(regTrim, 4'ha);
        wr(REGULATOR_CTRL_REG_OFS, 32'h3);
        chk(regTrim, 4'h3);
        $display("clock test done");
    endtask
    task t_periph;
        for (int g = 0; g < 3; g++) begin
            wr(PERIPH_SW_RESET0_OFS + 8'(4 * g), 32'h100);
            chk(pr[32 * g +: 32], 32'h100);
            wr(PERIPH_SW_RESET0_OFS + 8'(4 * g), 32'h0);
            chk(pr[32 * g +: 32], 32'h0);
        end
        chk(coreRstN, 1);
        $display("peripheral test done");
    endtask
    task t_brown;
        wr(SUPPLY_FAULT_RESET_CTRL_OFS, 32'h0010_0001);
        @(posedge sys_clk) brownDetect <= 1;
        repeat (6) @(posedge sys_clk);
        brownDetect <= 0;
        rd(BROWN_STATUS_OFS, 32'h2);
        repeat (30) @(posedge sys_clk);
        rd(BROWN_STATUS_OFS, 32'h0);
        @(posedge sys_clk) brownDetect <= 1;
        repeat (30) @(negedge sys_clk);
        chk(brownIrq, 1);
        chk(coreRstN, 1);
        @(posedge sys_clk) brownDetect <= 0;
        repeat (30) @(posedge sys_clk);
        wr(BROWN_STATUS_OFS, 32'h1);
        chk(brownIrq, 0);
        $display("brown-out test done");
    endtask
    // Each reset source in turn: 0 brown, 1 core, 2 watchdog, 3 regulator, 4 pin
    task t_resets;
        exp = {26'h0, CAUSE_RST};
        for (int s = 0; s < 5; s++) begin
            if (s == 0) wr(SUPPLY_FAULT_RESET_CTRL_OFS, 32'h2);
            if (s == 2) wr(WDOG_RELOAD_VALUE_OFS, 32'h10);
            if (s == 2) wr(WDOG_CTRL_OFS, 32'h3);
            if (s == 3) wr(REGULATOR_CTRL_REG_OFS, 32'h105);
            @(posedge sys_clk) {brownDetect, coreSysResetReq, regFaultDetect, extRstPinN} <= {s == 0, s == 1, s == 3, s != 4};
            if (s == 2) begin
                repeat (20) @(negedge sys_clk);
                chk({wdogIrq, coreRstN}, 2'b11);
            end
            waitCore(0);
            @(posedge sys_clk) {brownDetect, coreSysResetReq, regFaultDetect, extRstPinN} <= 4'b0001;
            waitCore(1);
            exp = (s == 4) ? 32'h1 : exp | (32'h1 << (s + 2));
            rd(RESET_CAUSE_REG_OFS, exp);
        end
        $display("reset source test done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1;
        waitCore(1);
        t_defaults;
        t_clock;
        t_periph;
        t_brown;
        t_resets;
        finish_test;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
